// *** verilog/ast_pkg.sv ***
package ast_pkg;
  // avalon register map, byte addresses
  localparam logic [11:0] OFS_DATA = 12'h000;
  localparam logic [11:0] OFS_FLAG = 12'h018;
  localparam logic [11:0] OFS_IBRD = 12'h024;
  localparam logic [11:0] OFS_FBRD = 12'h028;
  localparam logic [11:0] OFS_LCR  = 12'h02C;
  localparam logic [11:0] OFS_CTL  = 12'h030;
  localparam logic [11:0] OFS_IFLS = 12'h034;
  localparam logic [11:0] OFS_ICR  = 12'h044;
  // port_control_reg fields
  localparam int unsigned CTL_EN_BIT  = 0;
  localparam int unsigned CTL_TXE_BIT = 8;
  localparam int unsigned CTL_RXE_BIT = 9;
  localparam logic        CTL_EN_RST  = 1'b0;
  localparam logic        CTL_TXE_RST = 1'b1;
  localparam logic        CTL_RXE_RST = 1'b1;
  // level select and event clear
  localparam int unsigned IFLS_TX_LSB = 0;
  localparam int unsigned IFLS_RX_LSB = 3;
  localparam logic [5:0]  IFLS_RST    = 6'h12;
  localparam int unsigned ICR_RTO_BIT = 6;
  // port_flag_reg fields
  localparam int unsigned FL_BUSY  = 3;
  localparam int unsigned FL_RXFE  = 4;
  localparam int unsigned FL_TXFF  = 5;
  localparam int unsigned FL_RXFF  = 6;
  localparam int unsigned FL_TXFE  = 7;
  localparam int unsigned FL_RXLVL = 8;
  localparam int unsigned FL_TXLVL = 9;
  localparam int unsigned FL_RTO   = 10;
  // queues
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned PTR_W      = 4;
  localparam int unsigned CNT_W      = 5;
  localparam logic [4:0]  DEPTH_FULL = 5'h10;
  localparam logic [4:0]  DEPTH_HOLD = 5'h01;
  // bit timing in oversample ticks
  localparam logic [3:0]  TICK_LAST     = 4'hF;
  localparam logic [3:0]  START_SAMPLE  = 4'h7;
  localparam int unsigned TICKS_PER_BIT = 16;
  localparam int unsigned TIMEOUT_BITS  = 32;
  localparam int unsigned TIMEOUT_TICKS = TIMEOUT_BITS * TICKS_PER_BIT;
  localparam int unsigned TO_W          = 10;
  // divisor counts in 1/64 of a clock
  localparam logic [22:0] FRAC_STEP   = 23'h000040;
  localparam logic [2:0]  MIN_BITS_M1 = 3'h4;
  localparam logic [1:0]  WLEN_MAX    = 2'h3;
  localparam int unsigned BYTE_W      = 8;

  typedef struct packed {
    logic       sps;
    logic [1:0] wlen;
    logic       queue_enable_bit;
    logic       stp2;
    logic       eps;
    logic       pen;
    logic       brk;
  } ast_lcr_type;

  typedef struct packed {
    logic [15:0] ibrd;
    logic [5:0]  fbrd;
    ast_lcr_type lcr;
  } ast_cfg_type;

  typedef struct packed {
    logic       oe;
    logic       be;
    logic       pe;
    logic       fe;
    logic [7:0] data;
  } ast_rxent_type;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_START = 3'h1,
    ST_DATA  = 3'h3,
    ST_PAR   = 3'h2,
    ST_STOP  = 3'h6
  } ast_state_type;

  // fill level in entries for each eighth setting
  function automatic logic [4:0] ast_level(input logic [2:0] sel);
    case (sel)
      3'h0:    return 5'h02;
      3'h1:    return 5'h04;
      3'h2:    return 5'h08;
      3'h3:    return 5'h0C;
      default: return 5'h0E;
    endcase
  endfunction

  function automatic logic [31:0] ast_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (be[i])
        r[i*BYTE_W +: BYTE_W] = nw[i*BYTE_W +: BYTE_W];
    return r;
  endfunction
endpackage

// *** verilog/ast_uart.sv ***
`timescale 1ns/10ps
// How it works
// - divisor is 16-bit integer plus 6-bit fraction
// - divisor equals clock over sixteen times baud
// - oversample tick at sixteen times baud rate
// - divisors and line control load together
// - start, data lsb first, parity, stop bits
// - five to eight data bits
// - even, odd, stick or no parity; 1-2 stops
// - sixteen-entry queues, receive entries carry four flags
// - depth selectable, single entry holding mode
// - fill levels at eighths of the depth
// - queue write starts frames while enabled, back to back
// - busy until queue empty and shifter done
// - separate transmit and receive enables, set at reset
// - disabling finishes the current character first
// - falling edge, recheck low on eighth tick
// - data sampled every sixteenth tick
// - parity checked after data bits
// - low stop sample flags framing error
// - overrun, parity, framing, break stored with character
// - queues start as single entries until enabled
// - data read twelve bits, write eight bits
// - receive timeout after 32 idle bit periods
module ast_uart
  import ast_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        nrst,
  // avalon-mm slave
  input  wire logic [11:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output      logic [31:0] avs_readdata,
  output      logic        avs_waitrequest,
  // serial lines
  input  wire logic        serial_in_line,
  output      logic        serial_out_line
);

  logic          wait_r;
  logic [31:0]   rdata_r;
  logic [31:0]   rd_mux;
  logic          req;
  logic          wr_acc;
  logic          rd_acc;
  logic [15:0]   ibrd_r;
  logic [5:0]    fbrd_r;
  ast_cfg_type   cfg_r;
  logic          ctl_en_r;
  logic          txe_r;
  logic          rxe_r;
  logic [5:0]    ifls_r;
  logic [22:0]   acc_r;
  logic [22:0]   acc_sum;
  logic [22:0]   div_fx;
  logic          tick_r;
  logic [4:0]    cap;
  logic [7:0]    txq [FIFO_DEPTH];
  logic [3:0]    tx_wp_r;
  logic [3:0]    tx_rp_r;
  logic [4:0]    tx_cnt_r;
  logic          tx_push;
  logic          tx_launch;
  logic          tx_stop_done;
  ast_state_type tx_st_r;
  logic [3:0]    tx_tk_r;
  logic [2:0]    tx_bit_r;
  logic [7:0]    tx_sh_r;
  logic          tx_par_r;
  logic          txd_r;
  logic [7:0]    tx_head;
  logic [7:0]    len_mask;
  logic [2:0]    nbits_m1;
  logic          busy;
  logic          rx_m_r;
  logic          rx_s_r;
  logic          rx_prev_r;
  ast_state_type rx_st_r;
  logic [3:0]    rx_tk_r;
  logic [2:0]    rx_bit_r;
  logic [7:0]    rx_sh_r;
  logic          rx_par_r;
  logic          rx_zero_r;
  logic          rx_sample;
  logic          rx_push;
  logic          rx_pop;
  ast_rxent_type rx_ent;
  ast_rxent_type rxq [FIFO_DEPTH];
  logic [3:0]    rx_wp_r;
  logic [3:0]    rx_rp_r;
  logic [4:0]    rx_cnt_r;
  logic          ovr_r;
  logic [9:0]    to_cnt_r;
  logic          rto_r;
  logic          rto_set;
  logic [4:0]    rx_thr;
  logic [4:0]    tx_thr;
  logic [31:0]   flags;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  assign avs_readdata    = rdata_r;
  assign avs_waitrequest = wait_r;
  assign serial_out_line = txd_r;

  // one wait cycle per access; the effect lands on the release edge
  assign req    = avs_read | avs_write;
  assign wr_acc = avs_write & ~wait_r;
  assign rd_acc = avs_read & ~wait_r;

  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
      wait_r <= 1'b1;
    else
      wait_r <= ~(req & wait_r);

  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
      rdata_r <= '0;
    else if (avs_read & wait_r)
      rdata_r <= rd_mux;

  assign flags = (32'(busy) << FL_BUSY) | (32'(rx_cnt_r == '0) << FL_RXFE)
               | (32'(tx_cnt_r >= cap) << FL_TXFF) | (32'(rx_cnt_r >= cap) << FL_RXFF)
               | (32'(tx_cnt_r == '0) << FL_TXFE) | (32'(rx_cnt_r >= rx_thr) << FL_RXLVL)
               | (32'(tx_cnt_r <= tx_thr) << FL_TXLVL) | (32'(rto_r) << FL_RTO);

  always_comb
  begin
    if (avs_address == OFS_DATA)
      rd_mux = 32'(rxq[rx_rp_r]);
    else if (avs_address == OFS_FLAG)
      rd_mux = flags;
    else if (avs_address == OFS_IBRD)
      rd_mux = 32'(ibrd_r);
    else if (avs_address == OFS_FBRD)
      rd_mux = 32'(fbrd_r);
    else if (avs_address == OFS_LCR)
      rd_mux = 32'(cfg_r.lcr);
    else if (avs_address == OFS_CTL)
      rd_mux = (32'(ctl_en_r) << CTL_EN_BIT) | (32'(txe_r) << CTL_TXE_BIT) | (32'(rxe_r) << CTL_RXE_BIT);
    else if (avs_address == OFS_IFLS)
      rd_mux = 32'(ifls_r);
    else
      rd_mux = '0;
  end

  // staged divisors reach the engines only through cfg_r
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
    begin
      ibrd_r <= '0;
      fbrd_r <= '0;
      cfg_r  <= '0;
    end
    else if (wr_acc)
    begin
      if (avs_address == OFS_IBRD)
        ibrd_r <= 16'(ast_merge(32'(ibrd_r), avs_writedata, avs_byteenable));
      else if (avs_address == OFS_FBRD)
        fbrd_r <= 6'(ast_merge(32'(fbrd_r), avs_writedata, avs_byteenable));
      else if (avs_address == OFS_LCR)
        cfg_r <= {ibrd_r, fbrd_r, 8'(ast_merge(32'(cfg_r.lcr), avs_writedata, avs_byteenable))};
    end

  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
    begin
      ctl_en_r <= CTL_EN_RST;
      txe_r    <= CTL_TXE_RST;
      rxe_r    <= CTL_RXE_RST;
      ifls_r   <= IFLS_RST;
    end
    else if (wr_acc && avs_address == OFS_CTL)
    begin
      ctl_en_r <= avs_byteenable[CTL_EN_BIT / BYTE_W] ? avs_writedata[CTL_EN_BIT] : ctl_en_r;
      txe_r    <= avs_byteenable[CTL_TXE_BIT / BYTE_W] ? avs_writedata[CTL_TXE_BIT] : txe_r;
      rxe_r    <= avs_byteenable[CTL_RXE_BIT / BYTE_W] ? avs_writedata[CTL_RXE_BIT] : rxe_r;
    end
    else if (wr_acc && avs_address == OFS_IFLS)
      ifls_r <= 6'(ast_merge(32'(ifls_r), avs_writedata, avs_byteenable));

  // fractional accumulator in 1/64 clock units; a divisor under 1.0 stops it
  assign div_fx  = {1'b0, cfg_r.ibrd, cfg_r.fbrd};
  assign acc_sum = acc_r + FRAC_STEP;

  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
    begin
      acc_r  <= '0;
      tick_r <= 1'b0;
    end
    else if (div_fx < FRAC_STEP)
    begin
      acc_r  <= '0;
      tick_r <= 1'b0;
    end
    else if (acc_sum >= div_fx)
    begin
      acc_r  <= acc_sum - div_fx;
      tick_r <= 1'b1;
    end
    else
    begin
      acc_r  <= acc_sum;
      tick_r <= 1'b0;
    end

  assign cap      = cfg_r.lcr.queue_enable_bit ? DEPTH_FULL : DEPTH_HOLD;
  assign rx_thr   = cfg_r.lcr.queue_enable_bit ? ast_level(ifls_r[IFLS_RX_LSB +: 3]) : DEPTH_HOLD;
  assign tx_thr   = cfg_r.lcr.queue_enable_bit ? ast_level(ifls_r[IFLS_TX_LSB +: 3]) : '0;
  assign nbits_m1 = MIN_BITS_M1 + 3'(cfg_r.lcr.wlen);
  assign len_mask = 8'hFF >> (WLEN_MAX - cfg_r.lcr.wlen);
  assign tx_head  = txq[tx_rp_r] & len_mask;

  // transmit queue
  assign tx_push = wr_acc && avs_address == OFS_DATA && tx_cnt_r < cap;

  always_ff @(posedge mclk)
    if (tx_push)
      txq[tx_wp_r] <= avs_writedata[7:0];

  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
    begin
      tx_wp_r  <= '0;
      tx_rp_r  <= '0;
      tx_cnt_r <= '0;
    end
    else
    begin
      tx_wp_r  <= tx_wp_r + 4'(tx_push);
      tx_rp_r  <= tx_rp_r + 4'(tx_launch);
      tx_cnt_r <= tx_cnt_r + 5'(tx_push) - 5'(tx_launch);
    end

  // enable is looked at only between characters, so a frame always ends
  assign tx_stop_done = tx_st_r == ST_STOP && tx_tk_r == TICK_LAST && tx_bit_r == 3'(cfg_r.lcr.stp2);
  assign tx_launch = tick_r && tx_cnt_r != '0 && ctl_en_r && txe_r
                  && (tx_st_r == ST_IDLE || tx_stop_done);
  assign busy = tx_cnt_r != '0 || tx_st_r != ST_IDLE;

  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
    begin
      tx_st_r  <= ST_IDLE;
      tx_tk_r  <= '0;
      tx_bit_r <= '0;
      tx_sh_r  <= '0;
      tx_par_r <= 1'b0;
    end
    else if (tx_launch)
    begin
      tx_st_r  <= ST_START;
      tx_tk_r  <= '0;
      tx_sh_r  <= tx_head;
      tx_par_r <= cfg_r.lcr.sps ? ~cfg_r.lcr.eps : (^tx_head) ^ ~cfg_r.lcr.eps;
    end
    else if (tick_r && tx_st_r != ST_IDLE)
    begin
      tx_tk_r <= tx_tk_r + 4'h1;
      if (tx_tk_r == TICK_LAST)
        case (tx_st_r)
          ST_START:
          begin
            tx_st_r  <= ST_DATA;
            tx_bit_r <= '0;
          end
          ST_DATA:
          begin
            tx_sh_r  <= tx_sh_r >> 1;
            tx_bit_r <= tx_bit_r + 3'h1;
            if (tx_bit_r == nbits_m1)
            begin
              tx_st_r  <= cfg_r.lcr.pen ? ST_PAR : ST_STOP;
              tx_bit_r <= '0;
            end
          end
          ST_PAR:
            tx_st_r <= ST_STOP;
          default:
            if (tx_stop_done)
              tx_st_r <= ST_IDLE;
            else
              tx_bit_r <= tx_bit_r + 3'h1;
        endcase
    end

  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
      txd_r <= 1'b1;
    else if (cfg_r.lcr.brk)
      txd_r <= 1'b0;
    else
      case (tx_st_r)
        ST_START: txd_r <= 1'b0;
        ST_DATA:  txd_r <= tx_sh_r[0];
        ST_PAR:   txd_r <= tx_par_r;
        default:  txd_r <= 1'b1;
      endcase

  // line synchroniser; rx_m_r feeds nothing but rx_s_r
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
    begin
      rx_m_r    <= 1'b1;
      rx_s_r    <= 1'b1;
      rx_prev_r <= 1'b1;
    end
    else
    begin
      rx_m_r    <= serial_in_line;
      rx_s_r    <= rx_m_r;
      rx_prev_r <= rx_s_r;
    end

  assign rx_sample = tick_r && rx_tk_r == TICK_LAST;
  assign rx_push   = rx_sample && rx_st_r == ST_STOP;

  always_comb
  begin
    rx_ent.data = rx_sh_r >> (WLEN_MAX - cfg_r.lcr.wlen);
    rx_ent.fe   = ~rx_s_r;
    rx_ent.be   = rx_zero_r & ~rx_s_r;
    rx_ent.pe   = cfg_r.lcr.pen && rx_par_r != (cfg_r.lcr.sps ? ~cfg_r.lcr.eps : (^rx_ent.data) ^ ~cfg_r.lcr.eps);
    rx_ent.oe   = ovr_r;
  end

  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
    begin
      rx_st_r   <= ST_IDLE;
      rx_tk_r   <= '0;
      rx_bit_r  <= '0;
      rx_sh_r   <= '0;
      rx_par_r  <= 1'b0;
      rx_zero_r <= 1'b0;
    end
    else if (rx_st_r == ST_IDLE)
    begin
      if (rx_prev_r && !rx_s_r && ctl_en_r && rxe_r)
      begin
        rx_st_r <= ST_START;
        rx_tk_r <= '0;
      end
    end
    else if (rx_st_r == ST_START)
    begin
      if (tick_r && rx_tk_r == START_SAMPLE)
      begin
        rx_st_r   <= rx_s_r ? ST_IDLE : ST_DATA;
        rx_tk_r   <= '0;
        rx_bit_r  <= '0;
        rx_zero_r <= 1'b1;
      end
      else if (tick_r)
        rx_tk_r <= rx_tk_r + 4'h1;
    end
    else if (tick_r)
    begin
      rx_tk_r <= rx_tk_r + 4'h1;
      if (rx_sample)
      begin
        rx_zero_r <= rx_zero_r & ~rx_s_r;
        case (rx_st_r)
          ST_DATA:
          begin
            rx_sh_r  <= {rx_s_r, rx_sh_r[7:1]};
            rx_bit_r <= rx_bit_r + 3'h1;
            if (rx_bit_r == nbits_m1)
              rx_st_r <= cfg_r.lcr.pen ? ST_PAR : ST_STOP;
          end
          ST_PAR:
          begin
            rx_par_r <= rx_s_r;
            rx_st_r  <= ST_STOP;
          end
          default:
            rx_st_r <= ST_IDLE;
        endcase
      end
    end

  // receive queue; a character that finds it full is dropped
  assign rx_pop = rd_acc && avs_address == OFS_DATA && rx_cnt_r != '0;

  always_ff @(posedge mclk)
    if (rx_push && rx_cnt_r < cap)
      rxq[rx_wp_r] <= rx_ent;

  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
    begin
      rx_wp_r  <= '0;
      rx_rp_r  <= '0;
      rx_cnt_r <= '0;
      ovr_r    <= 1'b0;
    end
    else
    begin
      rx_wp_r  <= rx_wp_r + 4'(rx_push && rx_cnt_r < cap);
      rx_rp_r  <= rx_rp_r + 4'(rx_pop);
      rx_cnt_r <= rx_cnt_r + 5'(rx_push && rx_cnt_r < cap) - 5'(rx_pop);
      if (rx_push && rx_cnt_r >= cap)
        ovr_r <= 1'b1;
      else if (rx_push)
        ovr_r <= 1'b0;
    end

  // idle counter saturates so the event fires once per quiet spell
  assign rto_set = tick_r && rx_cnt_r != '0 && !rx_push && !rx_pop
                && to_cnt_r == TO_W'(TIMEOUT_TICKS - 1);

  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
      to_cnt_r <= '0;
    else if (rx_push || rx_pop || rx_cnt_r == '0)
      to_cnt_r <= '0;
    else if (tick_r && to_cnt_r != TO_W'(TIMEOUT_TICKS))
      to_cnt_r <= to_cnt_r + 10'h001;

  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
      rto_r <= 1'b0;
    else if (rto_set)
      rto_r <= 1'b1;
    else if (rx_cnt_r == '0 || (wr_acc && avs_address == OFS_ICR && avs_writedata[ICR_RTO_BIT]))
      rto_r <= 1'b0;

  a_busy_on_push: assert property (tx_push |=> busy[*2])
    else $error("busy not raised after queue write");
  a_break_line_low: assert property (cfg_r.lcr.brk |=> !serial_out_line)
    else $error("break did not hold line low");
  a_start_bit_low: assert property ($rose(tx_st_r == ST_START) && !cfg_r.lcr.brk |=> !serial_out_line)
    else $error("start bit not low");
  a_launch_enabled: assert property ($changed(tx_st_r) && tx_st_r == ST_START
                                     |-> $past(ctl_en_r) && $past(txe_r) && $past(tx_cnt_r) != '0)
    else $error("frame launched while disabled");
  a_false_start: assert property (rx_st_r == ST_START && tick_r && rx_tk_r == START_SAMPLE && rx_s_r
                                  |=> rx_st_r == ST_IDLE)
    else $error("glitch accepted as start bit");
  a_framing_flag: assert property (rx_push && rx_cnt_r < cap |=> rxq[$past(rx_wp_r)].fe == !$past(rx_s_r))
    else $error("framing flag mismatch");
  a_cfg_reload: assert property (wr_acc && avs_address == OFS_LCR && avs_byteenable[0]
                                 |=> cfg_r.ibrd == ibrd_r && cfg_r.lcr == $past(avs_writedata[7:0]))
    else $error("line control write did not load config");
  a_cfg_hold: assert property (!(wr_acc && avs_address == OFS_LCR) |=> $stable(cfg_r))
    else $error("config changed without line control write");
  a_tick_spacing: assert property (tick_r && div_fx >= {FRAC_STEP[21:0], 1'b0} |=> !tick_r)
    else $error("oversample tick too fast");
  a_depth_cap: assert property ((tx_cnt_r <= DEPTH_FULL) and (!cfg_r.lcr.queue_enable_bit && !$past(cfg_r.lcr.queue_enable_bit) |-> tx_cnt_r <= cap))
    else $error("queue beyond depth");
  a_timeout_cause: assert property ($rose(rto_r) |-> $past(rx_cnt_r) != '0 && $past(tick_r))
    else $error("timeout without pending data");

  c_frame_sent: cover property (tx_stop_done);
  c_char_stored: cover property (rx_push && rx_cnt_r < cap);
  c_overrun: cover property (rx_push && rx_cnt_r >= cap);
  c_timeout: cover property ($rose(rto_r));

endmodule

// *** tb/ast_remote.sv ***
`timescale 1ns/10ps
module ast_remote
  import ast_pkg::*;
(
  // clock
  input  wire logic       mclk,
  // serial lines, seen from the remote end
  input  wire logic       line_in,
  output      logic       line_out,
  // bits captured after each start bit
  input  wire logic [3:0] cap_len
);
  logic [12:0] cap_q[$];

  initial line_out = 1'b1;

  // one bit is 16 clocks: valid only while the divisor is 1.0
  task automatic send(input logic [13:0] frm);
    for (int i = 0; i < 14; i++)
      repeat (TICKS_PER_BIT) @(posedge mclk) line_out <= frm[i];
    @(posedge mclk) line_out <= 1'b1;
  endtask

  // too short to survive the mid-bit recheck
  task automatic pulse();
    @(posedge mclk) line_out <= 1'b0;
    repeat (4) @(posedge mclk);
    line_out <= 1'b1;
  endtask

  // sample mid-bit, as a real receiver would
  always
  begin : cap_blk
    logic [12:0] w;
    @(negedge line_in);
    w = '1;
    repeat (8) @(posedge mclk);
    for (int i = 0; i < cap_len; i++)
    begin
      repeat (TICKS_PER_BIT) @(posedge mclk);
      w[i] = line_in;
    end
    cap_q.push_back(w);
  end
endmodule

// *** tb/tb.sv ***
`timescale 1ns/10ps
module tb
  import ast_pkg::*;
();
  logic        mclk;
  logic        nrst;
  logic [11:0] adr;
  logic        rd;
  logic        wr;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        wreq;
  logic        sin;
  logic        sout;
  logic [3:0]  cap_len;
  logic [7:0]  lcr;
  logic [7:0]  pm[5] = '{8'h00, 8'h02, 8'h06, 8'h82, 8'h86};
  int          n_fail;
  int          num_checks;
  int          cyc;
  int          n_low;

  ast_uart dut (
    .mclk            (mclk),
    .nrst            (nrst),
    .avs_address     (adr),
    .avs_read        (rd),
    .avs_write       (wr),
    .avs_writedata   (wdat),
    .avs_byteenable  (4'hF),
    .avs_readdata    (rdat),
    .avs_waitrequest (wreq),
    .serial_in_line  (sin),
    .serial_out_line (sout)
  );

  ast_remote rem (
    .mclk     (mclk),
    .line_in  (sout),
    .line_out (sin),
    .cap_len  (cap_len)
  );

  always #20 mclk = ~mclk;

  task automatic final_report();
    if (n_fail == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      n_fail++;
      final_report();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge mclk);
    adr  <= a;
    wdat <= d;
    rd   <= ~w;
    wr   <= w;
    do @(posedge mclk); while (wreq !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(q & m, exp);
  endtask

  task automatic wait_flag(input int b, input logic v);
    logic [31:0] q;
    do bus(1'b0, OFS_FLAG, 32'h0, q); while (q[b] !== v);
  endtask

  function automatic logic [12:0] frame(input logic [7:0] c, input logic [7:0] l);
    int          nb;
    logic        p;
    logic [12:0] f;
    nb = int'(l[6:5]) + 5;
    f  = '1;
    p  = 1'b0;
    for (int k = 0; k < nb; k++)
    begin
      f[k] = c[k];
      p ^= c[k];
    end
    if (l[1])
      f[nb] = l[7] ? ~l[2] : (l[2] ? p : ~p);
    return f;
  endfunction

  task automatic setup(input logic [7:0] l);
    wr_reg(OFS_CTL, 32'h300);
    wr_reg(OFS_IBRD, 32'h1);
    wr_reg(OFS_FBRD, 32'h0);
    wr_reg(OFS_LCR, {24'h0, l});
    wr_reg(OFS_CTL, 32'h301);
  endtask

  task automatic tx_chk(input logic [7:0] c, input logic [7:0] l, input logic snd);
    cap_len = 4'(int'(l[6:5]) + 6 + l[1] + l[3]);
    if (snd)
      wr_reg(OFS_DATA, {24'h0, c});
    wait_flag(FL_BUSY, 1'b0);
    check(32'(rem.cap_q.pop_front()), 32'(frame(c, l)));
  endtask

  task automatic rx_chk(input logic [13:0] frm, input logic [31:0] exp);
    rem.send(frm);
    wait_flag(FL_RXFE, 1'b0);
    rd_chk(OFS_DATA, 32'hFFF, exp);
  endtask

  initial
  begin
    mclk       = 1'b0;
    nrst       = 1'b0;
    adr        = '0;
    rd         = 1'b0;
    wr         = 1'b0;
    wdat       = '0;
    cap_len    = 4'h9;
    n_fail     = 0;
    num_checks = 0;
    cyc        = 0;
    repeat (6) @(posedge mclk);
    nrst <= 1'b1;
    rd_chk(OFS_CTL, '1, 32'h300);
    rd_chk(OFS_FLAG, '1, 32'h290);
    rd_chk(OFS_IFLS, '1, 32'h12);
    wr_reg(12'h100, 32'hFF);
    rd_chk(12'h100, '1, 32'h0);
    // divisor only staged: no frame may leave yet
    wr_reg(OFS_IBRD, 32'h1);
    wr_reg(OFS_CTL, 32'h301);
    wr_reg(OFS_DATA, 32'h55);
    rd_chk(OFS_FLAG, 32'h28, 32'h28);
    repeat (64) @(posedge mclk);
    check(sout, 1'b1);
    wr_reg(OFS_LCR, 32'h60);
    repeat (40) @(posedge mclk);
    wr_reg(OFS_CTL, 32'h300);
    tx_chk(8'h55, 8'h60, 1'b0);
    for (int w = 0; w < 4; w++)
      foreach (pm[i])
      begin
        lcr = 8'(w << 5) | pm[i] | (w[0] ? 8'h08 : 8'h00);
        setup(lcr);
        tx_chk(8'hA5 ^ 8'(w), lcr, 1'b1);
      end
    // divisor 2.5: the start bit lasts 16 ticks of 2.5 clocks
    wr_reg(OFS_CTL, 32'h300);
    wr_reg(OFS_IBRD, 32'h2);
    wr_reg(OFS_FBRD, 32'h20);
    wr_reg(OFS_LCR, 32'h60);
    wr_reg(OFS_CTL, 32'h301);
    wr_reg(OFS_DATA, 32'hFF);
    @(negedge sout);
    n_low = 0;
    @(posedge mclk);
    while (sout === 1'b0)
    begin
      n_low++;
      @(posedge mclk);
    end
    check(n_low, 32'(TICKS_PER_BIT * 5 / 2));
    wait_flag(FL_BUSY, 1'b0);
    setup(8'h61);
    repeat (4) @(posedge mclk);
    check(sout, 1'b0);
    setup(8'h70);
    repeat (220) @(posedge mclk);
    rem.cap_q.delete();
    wr_reg(OFS_CTL, 32'h300);
    for (int i = 0; i < 17; i++)
      wr_reg(OFS_DATA, 32'(i));
    rd_chk(OFS_FLAG, 32'h2A8, 32'h28);
    wr_reg(OFS_CTL, 32'h301);
    for (int i = 0; i < 16; i++)
      tx_chk(8'(i), 8'h70, 1'b0);
    check(rem.cap_q.size(), 0);
    setup(8'h66);
    rx_chk({frame(8'h3C, 8'h66), 1'b0}, 32'h03C);
    rx_chk({frame(8'h3C, 8'h66) ^ 13'h100, 1'b0}, 32'h23C);
    rx_chk({frame(8'h3C, 8'h66) & ~13'h200, 1'b0}, 32'h13C);
    rx_chk(14'h0, 32'h500);
    rem.pulse();
    repeat (300) @(posedge mclk);
    rd_chk(OFS_FLAG, 32'h10, 32'h10);
    // single-entry mode: second char finds the holder full
    rem.send({frame(8'h11, 8'h66), 1'b0});
    rem.send({frame(8'h22, 8'h66), 1'b0});
    repeat (600) @(posedge mclk);
    rd_chk(OFS_FLAG, 32'h550, 32'h540);
    wr_reg(OFS_ICR, 32'h40);
    rd_chk(OFS_FLAG, 32'h400, 32'h0);
    rd_chk(OFS_DATA, 32'hFFF, 32'h011);
    rx_chk({frame(8'h33, 8'h66), 1'b0}, 32'h833);
    final_report();
  end
endmodule
